// [mrb_burst_if.sv]
// interface: start column and mode between burst engine and column generator
interface mrb_burst_if;
  import mrb_pkg::*;
  logic [2:0] start_col;
  logic       long_burst;
  logic       interleave;
  logic [2:0] beat;
  logic [2:0] col;
  modport ctl (output start_col, output long_burst, output interleave, output beat,
               input col);
  modport gen (input start_col, input long_burst, input interleave, input beat,
               output col);
endinterface

// [mrb_col_gen.sv]
// column generator: low column bits for one burst beat
module mrb_col_gen
  import mrb_pkg::*;
(
  mrb_burst_if.gen bif
);
  wire [2:0] seq_col;
  wire [2:0] ilv_col;
  wire [1:0] nib_low;
  wire       nib_hi;
  // sequential wraps in nibble; upper nibble toggles after four beats
  assign nib_low = 2'(bif.start_col[1:0] + bif.beat[1:0]);
  assign nib_hi  = bif.long_burst ? (bif.start_col[2] ^ bif.beat[2])
                                  : bif.start_col[2];
  assign seq_col = {nib_hi, nib_low};
  assign ilv_col = bif.long_burst ? (bif.start_col ^ bif.beat)
                                  : {bif.start_col[2], bif.start_col[1:0] ^ bif.beat[1:0]};
  assign bif.col = bif.interleave ? ilv_col : seq_col;
endmodule

// [mrb_ctl_model.sv]
// controller model: drives command and address pins of the mode block
module mrb_ctl_model
  import mrb_pkg::*;
(
  input  wire logic        i_clk,
  output logic             o_cs_n,
  output logic             o_ras_n,
  output logic             o_cas_n,
  output logic             o_we_n,
  output logic [1:0]       o_ba,
  output logic [13:0]      o_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  // start deselected, never an accidental command
  initial begin
    {o_cs_n, o_ras_n, o_cas_n, o_we_n} = 4'hf;
    o_ba = 2'h0;
    o_addr = 14'h0000;
  end
  // one command for the next edge; only legal codes unless a test asks
  task automatic put(input logic [3:0] c, input logic [1:0] b, input logic [13:0] a);
    {o_cs_n, o_ras_n, o_cas_n, o_we_n} = c;
    o_ba = b;
    o_addr = a;
  endtask
  // deselect; address flips so a stale value never looks held
  task automatic idle();
    o_cs_n = 1'b1;
    o_addr = ~o_addr;
  endtask
  // mode set, then quiet past the set cycle time (banks assumed idle)
  task automatic load_mode(input logic [13:0] w);
    put(CMD_MRS, 2'h0, w);
    repeat (TMRD_CYC + 1) begin
      @(posedge i_clk);
      #1;
      idle();
    end
  endtask
endmodule

// [mrb_mode_decode.sv]
// mode register field decoder with reserved code checks
module mrb_mode_decode
  import mrb_pkg::*;
(
  input  wire logic [13:0] i_mode,
  input  wire logic        i_byte_wide,
  output logic             o_len8,
  output logic             o_len_ok,
  output logic [2:0]       o_cas_lat,
  output logic             o_cas_ok,
  output logic [3:0]       o_wr_cyc,
  output logic             o_wr_ok,
  output logic             o_mode_ok
);
  wire [2:0] bl_code;
  wire [2:0] cl_code;
  wire [2:0] wr_code;
  assign bl_code   = i_mode[BL_LSB+:3];
  assign cl_code   = i_mode[CL_LSB+:3];
  assign wr_code   = i_mode[WR_LSB+:3];
  assign o_len8    = (bl_code == BL_CODE_8);
  assign o_len_ok  = (bl_code == BL_CODE_4) || (bl_code == BL_CODE_8);
  assign o_cas_lat = cl_code;
  assign o_cas_ok  = (cl_code >= CL_CODE_MIN) && (cl_code <= CL_CODE_MAX);
  assign o_wr_cyc  = 4'({1'b0, wr_code} + 4'h1);
  assign o_wr_ok   = (wr_code >= WR_CODE_MIN) && (wr_code <= WR_CODE_MAX);
  // test bit, and the unused top bit on a byte-wide part, must be clear for a usable setting
  assign o_mode_ok = o_len_ok && o_cas_ok && o_wr_ok && !i_mode[TM_BIT]
                     && !(i_byte_wide && i_mode[A13_BIT]);
endmodule

// [mrb_pkg.sv]
// package: mode register fields, command codes and burst sequencing constants
// Operation
// - mode register loads on command with cs, ras, cas, we, bank bits all low
// - test bit low for normal use; dll reset bit high requests reset
// - only lengths four and eight, codes 010 and 011 supported
// - order select bit low gives sequential, high gives interleaved
// - sequential eight-beat bursts wrap inside nibble, then other nibble same pattern
// - sequential start five gives 5,6,7,4,1,2,3,0; start three 3,0,1,2,7,4,5,6
// - interleaved column equals start low bits xor beat number
// - back-to-back reads or writes flow without gaps
// - no burst stop command exists or is supported
// - recovery cycles plus precharge time give auto-precharge write delay
// - exit select low uses fast exit, high uses slow exit
// - latency codes 011..110 mean 3..6, others reserved
// - address line 13 exists only for byte-wide part and is zero
package mrb_pkg;
  localparam int          ADDR_W       = 14;
  localparam int          BL_LSB       = 0;
  localparam int          BT_BIT       = 3;
  localparam int          CL_LSB       = 4;
  localparam int          TM_BIT       = 7;
  localparam int          DLL_BIT      = 8;
  localparam int          WR_LSB       = 9;
  localparam int          PD_BIT       = 12;
  localparam int          A13_BIT      = 13;
  localparam logic [2:0]  BL_CODE_4    = 3'h2;
  localparam logic [2:0]  BL_CODE_8    = 3'h3;
  localparam logic [2:0]  CL_CODE_MIN  = 3'h3;
  localparam logic [2:0]  CL_CODE_MAX  = 3'h6;
  localparam logic [2:0]  WR_CODE_MIN  = 3'h1;
  localparam logic [2:0]  WR_CODE_MAX  = 3'h5;
  localparam logic [13:0] MR_RESET     = 14'h0000;
  localparam logic [3:0]  TRP_CYC      = 4'h3;
  localparam logic [3:0]  TMRD_CYC     = 4'h2;
  // command encoding {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0]  CMD_MRS      = 4'h0;
  localparam logic [3:0]  CMD_RD       = 4'h5;
  localparam logic [3:0]  CMD_WR       = 4'h4;
  localparam logic [3:0]  CMD_BST      = 4'h6;
  typedef enum logic [1:0] {
    MRB_IDLE  = 2'b00,
    MRB_READ  = 2'b01,
    MRB_WRITE = 2'b11
  } mrb_state_t;
endpackage

// [mrb_top.sv]
// mode register capture and burst column sequencer
module mrb_top
  import mrb_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  input  wire logic        i_cs_n,
  input  wire logic        i_ras_n,
  input  wire logic        i_cas_n,
  input  wire logic        i_we_n,
  input  wire logic [1:0]  i_ba,
  input  wire logic [13:0] i_addr,
  input  wire logic        i_byte_wide,
  output logic [13:0]      o_base_mode_register,
  output logic             o_burst_order_select,
  output logic             o_burst_len8,
  output logic [2:0]       o_cas_latency,
  output logic             o_test_mode_bit,
  output logic             o_dll_reset_pulse,
  output logic [3:0]       o_wr_recovery_cyc,
  output logic [4:0]       o_ap_write_delay,
  output logic             o_power_down_exit_select,
  output logic             o_mode_valid,
  output logic             o_burst_active,
  output logic             o_burst_write,
  output logic [2:0]       o_burst_col,
  output logic             o_burst_last,
  output logic             o_cmd_error
);
  mrb_burst_if bif ();
  mrb_state_t  state_reg, state_next;
  logic [13:0] mode_reg;
  logic [2:0]  start_reg, beat_reg, beat_next;
  logic        dll_reg, err_reg, valid_reg;
  logic [2:0]  col_reg;
  logic        last_reg;
  logic [3:0]  mrd_cnt_reg;
  wire         len8, len_ok, cas_ok, wr_ok, mode_ok;
  wire [2:0]   cas_lat;
  wire [3:0]   wr_cyc;
  wire [3:0]   cmd;
  wire         is_mrs, is_rd, is_wr, is_bst;
  wire         in_burst, at_last, new_burst, bad_interrupt;
  wire         accept;
  wire [2:0]   beat_end;

  mrb_mode_decode u_dec (
    .i_mode      (mode_reg),
    .i_byte_wide (i_byte_wide),
    .o_len8      (len8),
    .o_len_ok    (len_ok),
    .o_cas_lat   (cas_lat),
    .o_cas_ok    (cas_ok),
    .o_wr_cyc    (wr_cyc),
    .o_wr_ok     (wr_ok),
    .o_mode_ok   (mode_ok)
  );

  mrb_col_gen u_col (
    .bif (bif.gen)
  );

  // command decode from the control pins
  assign cmd      = {i_cs_n, i_ras_n, i_cas_n, i_we_n};
  assign is_mrs   = (cmd == CMD_MRS) && (i_ba == 2'h0);
  assign is_rd    = (cmd == CMD_RD);
  assign is_wr    = (cmd == CMD_WR);
  assign is_bst   = (cmd == CMD_BST);
  assign in_burst = (state_reg != MRB_IDLE);
  assign beat_end = len8 ? 3'h7 : 3'h3;
  assign at_last  = in_burst && (beat_reg == beat_end);
  // a new burst may start on the last beat, giving gapless streams
  assign new_burst = (is_rd || is_wr) && (!in_burst || at_last || len8);
  // illegal: interrupting length four, mixing kinds, a stop command, or a mode set during a burst
  assign bad_interrupt = (in_burst && !at_last && (is_rd || is_wr)
                          && (!len8 || (is_rd != (state_reg == MRB_READ))))
                         || is_bst || (is_mrs && in_burst);
  // a refused cross-kind interrupt must not disturb the running burst
  assign accept = new_burst
                  && !(in_burst && !at_last && (is_rd != (state_reg == MRB_READ)));

  // feed the column generator
  assign bif.start_col  = start_reg;
  assign bif.long_burst = len8;
  assign bif.interleave = mode_reg[BT_BIT];
  assign bif.beat       = beat_reg;

  // burst state and beat counter
  always_comb begin
    state_next = state_reg;
    beat_next  = beat_reg;
    case (state_reg)
      MRB_IDLE: begin
        beat_next = 3'h0;
      end
      default: begin
        beat_next = 3'(beat_reg + 3'h1);
        if (at_last) begin
          state_next = MRB_IDLE;
          beat_next  = 3'h0;
        end
      end
    endcase
    // same-kind interrupt in length eight restarts the count
    if (accept) begin
      state_next = is_wr ? MRB_WRITE : MRB_READ;
      beat_next  = 3'h0;
    end
  end

  // mode register load; holds contents until the next set command outside a burst
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      mode_reg <= MR_RESET;
      dll_reg  <= 1'b0;
    end else begin
      dll_reg <= 1'b0;
      if (is_mrs && !in_burst) begin
        mode_reg <= i_addr;
        dll_reg  <= i_addr[DLL_BIT];
      end
    end
  end

  // set-cycle guard: commands inside the window are flagged
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      mrd_cnt_reg <= 4'h0;
    end else if (is_mrs && !in_burst) begin
      mrd_cnt_reg <= TMRD_CYC - 4'h1;
    end else if (mrd_cnt_reg != 4'h0) begin
      mrd_cnt_reg <= mrd_cnt_reg - 4'h1;
    end
  end

  // burst sequencer registers
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      state_reg <= MRB_IDLE;
      beat_reg  <= 3'h0;
      start_reg <= 3'h0;
    end else begin
      state_reg <= state_next;
      beat_reg  <= beat_next;
      if (accept) begin
        start_reg <= i_addr[2:0];
      end
    end
  end

  // registered outputs; column and last flag show the beat of the previous cycle
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      col_reg   <= 3'h0;
      last_reg  <= 1'b0;
      err_reg   <= 1'b0;
      valid_reg <= 1'b0;
    end else begin
      col_reg   <= bif.col;
      last_reg  <= at_last;
      // error flag is a pulse; no clear needed
      err_reg   <= bad_interrupt || ((is_rd || is_wr || is_mrs) && mrd_cnt_reg != 4'h0);
      valid_reg <= mode_ok;
    end
  end

  assign o_base_mode_register     = mode_reg;
  assign o_burst_order_select     = mode_reg[BT_BIT];
  assign o_burst_len8             = len8;
  assign o_cas_latency            = cas_lat;
  assign o_test_mode_bit          = mode_reg[TM_BIT];
  assign o_dll_reset_pulse        = dll_reg;
  assign o_wr_recovery_cyc        = wr_cyc;
  // auto-precharge delay: recovery plus precharge time
  assign o_ap_write_delay         = 5'({1'b0, wr_cyc} + {1'b0, TRP_CYC});
  assign o_power_down_exit_select = mode_reg[PD_BIT];
  assign o_mode_valid             = valid_reg;
  assign o_burst_active           = in_burst;
  assign o_burst_write            = (state_reg == MRB_WRITE);
  assign o_burst_col              = col_reg;
  assign o_burst_last             = last_reg;
  assign o_cmd_error              = err_reg;

  // assertions
  sequence s_mrs_load;
    is_mrs && !in_burst;
  endsequence

  AST_MRS_LOAD: assert property (@(posedge i_clk) disable iff (!i_rstn)
    s_mrs_load |=> (mode_reg == $past(i_addr)))
    else $error("mode register not loaded");
  AST_DLL_PULSE: assert property (@(posedge i_clk) disable iff (!i_rstn)
    dll_reg |-> $past(is_mrs && i_addr[DLL_BIT]))
    else $error("dll reset pulse without request");
  AST_LEN4_END: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (state_reg == MRB_IDLE && new_burst && !len8 && !is_mrs) ##1 (!new_burst)[*4]
      |=> !in_burst || new_burst)
    else $error("length four burst wrong length");
  AST_SEQ_NIBBLE: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (in_burst && !mode_reg[BT_BIT]) |-> (bif.col[1:0] == 2'(start_reg[1:0] + beat_reg[1:0])))
    else $error("sequential column not nibble wrapped");
  AST_SEQ_FIVE: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (in_burst && len8 && !mode_reg[BT_BIT] && start_reg == 3'h5 && beat_reg == 3'h4)
      |-> bif.col == 3'h1)
    else $error("sequential start five beat four wrong");
  AST_ILV_XOR: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (in_burst && len8 && mode_reg[BT_BIT]) |-> bif.col == (start_reg ^ beat_reg))
    else $error("interleaved column not xor");
  AST_SEAMLESS: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (at_last && is_rd && !is_mrs) |=> (state_reg == MRB_READ && beat_reg == 3'h0))
    else $error("back to back read has a gap");
  AST_NO_BST: assert property (@(posedge i_clk) disable iff (!i_rstn)
    is_bst |=> o_cmd_error)
    else $error("stop command not flagged");
  AST_AP_DELAY: assert property (@(posedge i_clk) disable iff (!i_rstn)
    o_ap_write_delay == 5'(mode_reg[WR_LSB+:3] + 5'h1 + TRP_CYC))
    else $error("auto precharge delay wrong");
  AST_PD_SEL: assert property (@(posedge i_clk) disable iff (!i_rstn)
    s_mrs_load |=> o_power_down_exit_select == $past(i_addr[PD_BIT]))
    else $error("power down exit select not captured");
endmodule

// [test_sdram_mode_register_burst_order.sv]
// self-checking bench for mode register capture and burst column order
module test_sdram_mode_register_burst_order
  import mrb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_clk = 1'b0;
  logic        i_rstn = 1'b0;
  logic        i_byte_wide = 1'b1;
  logic        cs_n, ras_n, cas_n, we_n;
  logic [1:0]  ba;
  logic [13:0] addr, o_mr;
  logic        o_bt, o_len8, o_tm, o_dll, o_pd, o_valid, o_act, o_wr, o_last, o_err;
  logic [2:0]  o_cl, o_col;
  logic [3:0]  o_wrc;
  logic [4:0]  o_apd;
  logic        len8, inter;
  int          err_total = 0;
  int          check_count = 0;
  int          dll_cnt = 0;
  always #2.5 i_clk = ~i_clk;
  mrb_ctl_model ctl (.i_clk(i_clk), .o_cs_n(cs_n), .o_ras_n(ras_n), .o_cas_n(cas_n),
                     .o_we_n(we_n), .o_ba(ba), .o_addr(addr));
  mrb_top dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_cs_n(cs_n), .i_ras_n(ras_n),
    .i_cas_n(cas_n), .i_we_n(we_n), .i_ba(ba), .i_addr(addr), .i_byte_wide(i_byte_wide),
    .o_base_mode_register(o_mr), .o_burst_order_select(o_bt), .o_burst_len8(o_len8),
    .o_cas_latency(o_cl), .o_test_mode_bit(o_tm), .o_dll_reset_pulse(o_dll),
    .o_wr_recovery_cyc(o_wrc), .o_ap_write_delay(o_apd), .o_power_down_exit_select(o_pd),
    .o_mode_valid(o_valid), .o_burst_active(o_act), .o_burst_write(o_wr),
    .o_burst_col(o_col), .o_burst_last(o_last), .o_cmd_error(o_err));
  // pulse counter; a stuck pulse shows as a count above one
  always @(posedge i_clk) if (o_dll === 1'b1) dll_cnt++;
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    check_count++;
    if (s !== e) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic summarize();
    $display("errors %0d checks %0d", err_total, check_count);
    if (err_total == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // expected column of beat n from the start column
  function automatic logic [2:0] col_of(input logic [2:0] st, input logic [2:0] n);
    if (inter) return st ^ n;
    if (!len8) return {st[2], st[1:0] + n[1:0]};
    return {st[2] ^ n[2], st[1:0] + n[1:0]};
  endfunction
  task automatic set_mode(input logic [2:0] bl, input logic bt, input logic [2:0] cl,
                          input logic [2:0] wr, input logic pd);
    logic [13:0] w;
    w = {1'b0, pd, wr, 2'b00, cl, bt, bl};
    ctl.load_mode(w);
    len8 = (bl == BL_CODE_8);
    inter = bt;
    chk(o_mr, w);
    chk({o_len8, o_bt, o_pd, o_tm}, {len8, bt, pd, 1'b0});
    chk(o_cl, cl);
    chk(o_wrc, {1'b0, wr} + 4'h1);
    chk(o_apd, {2'b00, wr} + 5'h4);
    chk(o_valid, 1'b1);
  endtask
  // nb commands every sp cycles; optional stray command at cycle 2
  task automatic stream(input int nb, input int sp, input logic wr, input logic [2:0] st,
                        input logic [3:0] bad);
    int L, T, k, ci, n, errs;
    logic [13:0] mr0;
    L = len8 ? 8 : 4;
    T = (nb - 1) * sp + L;
    errs = 0;
    mr0 = o_mr;
    for (int c = 0; c <= T; c++) begin
      if (c % sp == 0 && c / sp < nb) ctl.put(wr ? CMD_WR : CMD_RD, 2'h0, {11'h0, 3'(st + 3 * (c / sp))});
      else if (c == 2 && bad !== 4'hf) ctl.put(bad, 2'h0, 14'h0000);
      else ctl.idle();
      @(posedge i_clk);
      #1;
      if (o_err === 1'b1) errs++;
      if (c < T) chk({o_act, o_wr}, {1'b1, wr});
      if (c == T) chk(o_act, 1'b0);
      if (c >= 1) begin
        k = c - 1;
        ci = (k / sp < nb) ? k / sp : nb - 1;
        n = k - ci * sp;
        chk(o_col, col_of(3'(st + 3 * ci), 3'(n)));
        chk(o_last, n == L - 1);
      end
    end
    chk(errs, bad !== 4'hf);
    chk(o_mr, mr0);
  endtask
  localparam logic [13:0] BADW [6] = '{14'h0231, 14'h0272, 14'h0032, 14'h0e32, 14'h02b2,
                                       14'h2232};
  // main sequence
  initial begin
    {len8, inter} = 2'b00;
    repeat (5) @(posedge i_clk);
    #1;
    i_rstn = 1'b1;
    chk({o_mr, o_valid}, 15'h0000);
    chk({o_apd, o_wrc}, {5'h4, 4'h1});
    for (int i = 0; i < 5; i++) begin
      set_mode(i[0] ? BL_CODE_8 : BL_CODE_4, i[1], 3'(3 + i % 4), 3'(i + 1), i[0]);
      for (int s = 0; s < 8; s++) stream(1, 8, s[0], 3'(s), 4'hf);
    end
    for (int i = 0; i < 6; i++) begin
      ctl.load_mode(BADW[i]);
      chk(o_valid, 1'b0);
    end
    dll_cnt = 0;
    ctl.load_mode(14'h0332);
    chk(dll_cnt, 1);
    set_mode(BL_CODE_8, 1'b0, 3'h5, 3'h2, 1'b0);
    stream(2, 8, 1'b0, 3'h5, 4'hf);
    stream(2, 8, 1'b1, 3'h3, 4'hf);
    stream(2, 4, 1'b0, 3'h5, 4'hf);
    stream(2, 4, 1'b1, 3'h1, 4'hf);
    stream(1, 8, 1'b0, 3'h5, CMD_WR);
    stream(1, 8, 1'b1, 3'h2, CMD_RD);
    stream(1, 8, 1'b0, 3'h6, CMD_BST);
    stream(1, 8, 1'b0, 3'h4, CMD_MRS);
    set_mode(BL_CODE_4, 1'b1, 3'h4, 3'h3, 1'b1);
    stream(1, 4, 1'b0, 3'h1, CMD_RD);
    stream(3, 4, 1'b1, 3'h2, 4'hf);
    summarize();
  end
  // hang guard
  initial begin
    #100us;
    err_total++;
    summarize();
  end
endmodule
